// File: rtl/csms_pkg.sv
// Purpose: Shared constants and types for the capacitive sense mode and timer select block.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes: Register layout lives here so the bench and the design agree.
package csms_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_OPTION = 8'h08;
  localparam logic [7:0] OFF_T1CTRL = 8'h0C;
  localparam logic [7:0] OFF_TMR0 = 8'h10;
  localparam logic [7:0] OFF_TMR1 = 8'h14;
  localparam logic [7:0] OFF_MODE = 8'h18;
  // Field positions in sense_control_reg0.
  localparam int CTRL0_EN_BIT = 7;
  localparam int CTRL0_REF_BIT = 6;
  localparam int CTRL0_RNG_LSB = 2;
  localparam int CTRL0_DIR_BIT = 1;
  localparam int CTRL0_T0X_BIT = 0;
  // Field positions in the option and timer1 control registers.
  localparam int OPT_T0CS_BIT = 5;
  localparam int T1_SRC_LSB = 6;
  localparam int T1_GE_BIT = 1;
  localparam int T1_ON_BIT = 0;
  // Reset values and encodings.
  localparam logic [1:0] RNG_RST = 2'h0;
  localparam logic [1:0] T1_SRC_OSC = 2'h3;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic T0CS_RST = 1'b1;
  localparam logic [1:0] T0_PRESCALE_LAST = 2'h3;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // Eight oscillator power modes, off included.
  typedef enum logic [2:0] {
    MODE_OFF, MODE_LO_LOW, MODE_LO_MED, MODE_LO_HIGH,
    MODE_NOISE, MODE_HI_LOW, MODE_HI_MED, MODE_HI_HIGH
  } csms_mode_t;

  // APB request group driven by the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } csms_apb_req_t;

  // APB answer group driven by this slave.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csms_apb_rsp_t;
endpackage

// File: rtl/csms_top.sv
// Purpose: Power mode decode, sense channel select and oscillator-clocked timers.
// Assumes: Comparator output and timer1 gate arrive asynchronously from pins.
// Notes: Oscillator edges are counted in the system clock domain, so the oscillator
// Notes: must run below half the system clock rate to be counted exactly.
// Notes: Timer0 takes the oscillator only with the external select set and option bit clear.
`timescale 1ns/1ps
`default_nettype none

module csms_top #(
  parameter bit HAS_HIGH_RANGE = 1'b1,
  parameter int TMR_W = 16
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire csms_pkg::csms_apb_req_t I_APB,
  output var csms_pkg::csms_apb_rsp_t O_APB,
  input wire logic I_OSC_CMP,
  input wire logic I_T0_PIN,
  input wire logic I_T1_GATE,
  output logic O_OSC_EN,
  output logic O_CUR_EN,
  output logic O_REF_HIGH,
  output logic [2:0] O_PWR_MODE,
  output logic [15:0] O_CHAN_SEL
);
  import csms_pkg::*;

  logic mod_en, ref_mode_sel, timer0_ext_src_sel, timer0_clk_src;
  logic timer1_on, timer1_gate_en;
  logic [1:0] current_range_sel, timer1_clk_src, t0_pre;
  logic [3:0] sense_channel_sel;
  logic [TMR_W-1:0] tmr0, tmr1, next_tmr0, next_tmr1;
  logic osc_s1, osc_s2, osc_s3, t0p_s1, t0p_s2, t0p_s3, gate_s1, gate_s2;
  csms_mode_t mode;

  // Mode decode; a part without the high range treats the reference bit as zero.
  function automatic csms_mode_t decode_mode(input logic en, input logic hi,
                                             input logic [1:0] rng);
    if (!en) begin
      decode_mode = MODE_OFF;
    end else begin
      decode_mode = csms_mode_t'({hi, rng});
    end
  endfunction

  // Bus decode and access strobes; the slave answers in the first access cycle.
  wire acc = I_APB.psel && I_APB.penable;
  wire wr = acc && I_APB.pwrite;
  wire hit_c0 = I_APB.paddr == OFF_CTRL0;
  wire hit_c1 = I_APB.paddr == OFF_CTRL1;
  wire hit_opt = I_APB.paddr == OFF_OPTION;
  wire hit_t1c = I_APB.paddr == OFF_T1CTRL;
  wire hit_t0 = I_APB.paddr == OFF_TMR0;
  wire hit_t1 = I_APB.paddr == OFF_TMR1;
  wire hit_md = I_APB.paddr == OFF_MODE;
  wire hit_any = hit_c0 || hit_c1 || hit_opt || hit_t1c || hit_t0 || hit_t1 || hit_md;
  wire eff_ref = HAS_HIGH_RANGE && ref_mode_sel;
  wire osc_rise = osc_s2 && !osc_s3;
  wire t0p_rise = t0p_s2 && !t0p_s3;

  // Power mode and analog steering outputs.
  assign mode = decode_mode(mod_en, eff_ref, current_range_sel);
  assign O_PWR_MODE = mode;
  assign O_REF_HIGH = eff_ref && mod_en;
  assign O_OSC_EN = mode != MODE_OFF;
  assign O_CUR_EN = O_OSC_EN && (mode != MODE_NOISE);
  assign O_CHAN_SEL = mod_en ? (16'h0001 << sense_channel_sel) : 16'h0000;

  // Timer0 count source. The oscillator is taken only with the external select set and
  // the option source bit cleared; with the option bit set the pin counts instead, and
  // with both clear the internal clock over four. Software must not pick this timer as
  // its time base while the oscillator clocks it, or the reading means nothing.
  wire t0_osc_sel = timer0_ext_src_sel && !timer0_clk_src;
  wire t0_tick = t0_osc_sel ? osc_rise
               : (timer0_clk_src ? t0p_rise : (t0_pre == T0_PRESCALE_LAST));
  // Timer1 sources other than the oscillator count every system clock.
  wire t1_src_tick = (timer1_clk_src == T1_SRC_OSC) ? osc_rise : 1'b1;
  wire t1_run = timer1_on && (!timer1_gate_en || gate_s2);
  wire t1_tick = t1_run && t1_src_tick;
  // A software write to a timer wins over a count in the same cycle.
  assign next_tmr0 = (wr && hit_t0) ? I_APB.pwdata[TMR_W-1:0]
                   : (t0_tick ? tmr0 + 1'b1 : tmr0);
  assign next_tmr1 = (wr && hit_t1) ? I_APB.pwdata[TMR_W-1:0]
                   : (t1_tick ? tmr1 + 1'b1 : tmr1);

  // Control word 0 as read back. The direction status bit is the synchronised
  // comparator level, so it lags the pin by two system clocks.
  wire logic [7:0] ctrl0_rd = {mod_en, eff_ref, 2'h0, current_range_sel,
                               osc_s2, timer0_ext_src_sel};

  // Read mux; unmapped reads return zero with an error.
  wire logic [31:0] rd_mux = !acc ? RDATA_NONE
      : hit_c0 ? 32'(ctrl0_rd)
      : hit_c1 ? 32'(sense_channel_sel)
      : hit_opt ? 32'({timer0_clk_src, 5'h00})
      : hit_t1c ? 32'({timer1_clk_src, 4'h0, timer1_gate_en, timer1_on})
      : hit_t0 ? 32'(tmr0)
      : hit_t1 ? 32'(tmr1)
      : hit_md ? 32'(mode)
      : RDATA_NONE;
  // The whole answer is one struct with one driver; the slave never waits.
  assign O_APB = '{pready: 1'b1, pslverr: acc && !hit_any, prdata: rd_mux};

  // Two-flop synchronisers; the third stage only serves edge detection.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
      {t0p_s1, t0p_s2, t0p_s3} <= 3'h0;
      {gate_s1, gate_s2} <= 2'h0;
    end else begin
      {osc_s1, osc_s2, osc_s3} <= {I_OSC_CMP, osc_s1, osc_s2};
      {t0p_s1, t0p_s2, t0p_s3} <= {I_T0_PIN, t0p_s1, t0p_s2};
      {gate_s1, gate_s2} <= {I_T1_GATE, gate_s1};
    end
  end

  // Control registers written by software.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {mod_en, ref_mode_sel, timer0_ext_src_sel} <= 3'h0;
      current_range_sel <= RNG_RST;
      sense_channel_sel <= CHAN_RST;
      timer0_clk_src <= T0CS_RST;
      {timer1_clk_src, timer1_gate_en, timer1_on} <= 4'h0;
    end else if (wr) begin
      if (hit_c0) begin
        mod_en <= I_APB.pwdata[CTRL0_EN_BIT];
        ref_mode_sel <= I_APB.pwdata[CTRL0_REF_BIT];
        current_range_sel <= I_APB.pwdata[CTRL0_RNG_LSB +: 2];
        timer0_ext_src_sel <= I_APB.pwdata[CTRL0_T0X_BIT];
      end else if (hit_c1) begin
        sense_channel_sel <= I_APB.pwdata[3:0];
      end else if (hit_opt) begin
        timer0_clk_src <= I_APB.pwdata[OPT_T0CS_BIT];
      end else if (hit_t1c) begin
        timer1_clk_src <= I_APB.pwdata[T1_SRC_LSB +: 2];
        timer1_gate_en <= I_APB.pwdata[T1_GE_BIT];
        timer1_on <= I_APB.pwdata[T1_ON_BIT];
      end
    end
  end

  // Timers and the internal divide-by-four prescaler.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tmr0 <= '0;
      tmr1 <= '0;
      t0_pre <= 2'h0;
    end else begin
      tmr0 <= next_tmr0;
      tmr1 <= next_tmr1;
      t0_pre <= t0_pre + 2'h1;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  // An oscillator rising edge seen while timer1 counts it, with no write.
  sequence t1_osc_edge_s;
    osc_rise && timer1_on && !timer1_gate_en && timer1_clk_src == 2'h3 && !(wr && hit_t1);
  endsequence
  sequence t0_osc_edge_s;
    osc_rise && t0_osc_sel && !(wr && hit_t0);
  endsequence

  noise_no_current_a: assert property (mod_en && eff_ref && current_range_sel == 2'h0 |->
    O_OSC_EN && !O_CUR_EN) else $error("Current flows in noise detection.");
  range_refs_a: assert property (O_REF_HIGH |-> mode inside {MODE_NOISE, MODE_HI_LOW,
    MODE_HI_MED, MODE_HI_HIGH}) else $error("Reference select disagrees with mode.");
  low_off_a: assert property (mod_en && !eff_ref && current_range_sel == 2'h0 |->
    O_PWR_MODE == 3'h0 && !O_OSC_EN) else $error("Low range code zero not off.");
  variant_a: assert property (!HAS_HIGH_RANGE |-> !O_REF_HIGH && O_PWR_MODE < 3'h4)
    else $error("High range used on a part without it.");
  t1_osc_count_a: assert property (t1_osc_edge_s |=> tmr1 == $past(tmr1) + 1'b1)
    else $error("Timer1 missed an oscillator edge.");
  t1_one_per_edge_a: assert property (osc_rise |=> !osc_rise)
    else $error("One oscillator edge gave two ticks.");
  t0_osc_count_a: assert property (t0_osc_edge_s |=> tmr0 == $past(tmr0) + 1'b1)
    else $error("Timer0 missed an oscillator edge.");
  t1_off_a: assert property (!timer1_on && !(wr && hit_t1) |=> $stable(tmr1))
    else $error("Timer1 counted while off.");
  t1_gated_a: assert property (timer1_on && timer1_gate_en && !gate_s2 && !(wr && hit_t1)
    |=> $stable(tmr1)) else $error("Timer1 counted with gate closed.");
  status_dir_a: assert property (osc_s2 && !osc_s3 |-> ##1 1'b1 ##0
    (!acc || !hit_c0 || O_APB.prdata[1] == osc_s2)) else $error("Direction status wrong.");
  chan_off_a: assert property (!mod_en |-> O_CHAN_SEL == 16'h0000)
    else $error("Channel driven while module disabled.");
  noise_counts_a: assert property (mode == MODE_NOISE ##0 t1_osc_edge_s |=>
    tmr1 != $past(tmr1)) else $error("Noise activity not counted.");
  // With both selects clear, timer0 follows the internal clock over four.
  t0_prescale_a: assert property (!timer0_clk_src && !timer0_ext_src_sel &&
    t0_pre == T0_PRESCALE_LAST && !(wr && hit_t0) |=> tmr0 == $past(tmr0) + 1'b1)
    else $error("Timer0 missed an internal tick.");
  // With the oscillator selected, only an oscillator edge or a write may move timer0.
  t0_osc_only_a: assert property (t0_osc_sel && !osc_rise && !(wr && hit_t0)
    |=> $stable(tmr0)) else $error("Timer0 counted without an oscillator edge.");
  // Timer1 counts every cycle on a non-oscillator source when on and ungated.
  t1_free_a: assert property (timer1_on && !timer1_gate_en &&
    timer1_clk_src != T1_SRC_OSC && !(wr && hit_t1) |=> tmr1 == $past(tmr1) + 1'b1)
    else $error("Timer1 not free running.");
  chan_onehot_a: assert property (mod_en |-> $onehot(O_CHAN_SEL))
    else $error("Enabled module routes no single channel.");
endmodule // csms_top

`default_nettype wire

// File: verif/csms_pad_model.sv
// Purpose: Touch pad model that closes the sense oscillator loop at the comparator input.
// Assumes: The pad swings only while the block drives current or noise couples in.
// Notes: Half periods are counted down, so the bench knows every edge it will see.
`timescale 1ns/1ps
`default_nettype none
module csms_pad_model #(
  parameter int HALF = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_drive,
  input wire logic i_noise,
  input wire logic i_start,
  input wire logic [7:0] i_halves,
  output logic o_cmp
);
  logic [7:0] left;
  logic [3:0] ph;
  // The comparator toggles every HALF cycles and freezes once its budget is spent.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      left <= 8'h00;
      ph <= 4'h0;
      o_cmp <= 1'b0;
    end else if (i_start) begin
      left <= i_halves;
      ph <= 4'h0;
    end else if (left != 8'h00 && (i_drive || i_noise)) begin
      ph <= (ph == 4'(HALF - 1)) ? 4'h0 : ph + 4'h1;
      if (ph == 4'(HALF - 1)) begin
        o_cmp <= ~o_cmp; // High while sourcing.
        left <= left - 8'h01;
      end
    end
  end
endmodule // csms_pad_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for mode decode, channel select and oscillator timers.
// Assumes: Zero-wait APB slave; the pad model supplies the comparator.
// Notes: A second instance without the high range shares every input.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  csms_apb_req_t req = '0;
  csms_apb_rsp_t rsp;
  logic cmp, osc_en, cur_en, ref_hi, err;
  logic gate = 1'b0, noise = 1'b0, start = 1'b0;
  logic [7:0] halves = 8'h00;
  logic [2:0] mode, mode_lo;
  logic [15:0] chan;
  logic [31:0] rd;
  int err_count = 0, checks_done = 0, cyc = 0;
  // Clock, plus a hang guard far above the few hundred cycles the run needs.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  csms_top csms_top_i (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_APB(req), .O_APB(rsp),
    .I_OSC_CMP(cmp), .I_T0_PIN(1'b0), .I_T1_GATE(gate), .O_OSC_EN(osc_en), .O_CUR_EN(cur_en),
    .O_REF_HIGH(ref_hi), .O_PWR_MODE(mode), .O_CHAN_SEL(chan));
  csms_top #(.HAS_HIGH_RANGE(1'b0)) csms_top_lo_i (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .I_APB(req), .O_APB(), .I_OSC_CMP(cmp), .I_T0_PIN(1'b0), .I_T1_GATE(gate), .O_OSC_EN(),
    .O_CUR_EN(), .O_REF_HIGH(), .O_PWR_MODE(mode_lo), .O_CHAN_SEL());
  csms_pad_model csms_pad_model_i (.i_clk(clk), .i_rst(rst), .i_drive(cur_en && chan != 16'h0),
    .i_noise(noise), .i_start(start), .i_halves(halves), .o_cmp(cmp));
  task automatic tally_and_finish();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One transfer, entered just after an edge; the wait on pready is kept though it is zero.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  // Clear a timer, let the pad swing n half periods, then read the count back.
  task automatic count(input logic [7:0] a, input logic [7:0] n, input logic [31:0] exp);
    apb(1'b1, a, 32'h0);
    halves <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (32'(n) * 4 + 8) @(posedge clk); // time base is a bench loop
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "timer count");
  endtask
  // Swing the pad n half periods, then read the direction status in control word 0.
  task automatic status(input logic [7:0] n, input logic [31:0] exp);
    halves <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (32'(n) * 4 + 8) @(posedge clk);
    apb(1'b0, OFF_CTRL0, 32'h0);
    chk(rd, exp, "direction status");
  endtask
  task automatic t_reset();
    chk({chan, 10'h0, mode, osc_en, cur_en, ref_hi}, 32'h0, "reset outputs");
    apb(1'b0, OFF_OPTION, 32'h0);
    chk(rd, 32'h20, "option reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_CTRL0, 32'h80 | (32'(i[2]) << CTRL0_REF_BIT) | (32'(i[1:0]) << 2));
      chk(32'(mode), 32'(i), "mode");
      chk({osc_en, cur_en, ref_hi}, {i != 0, i != 0 && i != 4, i[2] == 1'b1}, "en");
      chk(32'(mode_lo), 32'(i[1:0]), "low range only");
    end
  endtask
  task automatic t_chan();
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_CTRL1, 32'(c));
      chk(32'(chan), 32'h1 << c, "channel");
    end
    apb(1'b1, OFF_CTRL0, 32'h04);
    chk(32'(chan), 32'h0, "disabled");
  endtask
  task automatic t_timers();
    apb(1'b1, OFF_CTRL0, 32'h84);
    apb(1'b1, OFF_T1CTRL, 32'hC1);
    count(OFF_TMR1, 8'h0A, 32'h5);
    apb(1'b1, OFF_T1CTRL, 32'hC3);
    count(OFF_TMR1, 8'h06, 32'h0);
    gate <= 1'b1;
    count(OFF_TMR1, 8'h06, 32'h3);
    apb(1'b1, OFF_T1CTRL, 32'hC0);
    count(OFF_TMR1, 8'h04, 32'h0);
    status(8'h01, 32'h86);
    status(8'h01, 32'h84);
    apb(1'b1, OFF_CTRL0, 32'h85);
    apb(1'b1, OFF_OPTION, 32'h0);
    count(OFF_TMR0, 8'h08, 32'h4);
  endtask
  task automatic t_noise();
    apb(1'b1, OFF_CTRL0, 32'hC0);
    apb(1'b1, OFF_T1CTRL, 32'hC1);
    chk(32'(cur_en), 32'h0, "noise current");
    noise <= 1'b1;
    count(OFF_TMR1, 8'h08, 32'h4);
  endtask
  // Reset for four cycles, then one scenario after another.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_chan();
    t_timers();
    t_noise();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
